// ===== src/flash_rww_self_programming.sv
// Purpose: Self-programming sequencer with read-while-write control
// Assumes: CPU tells us the page it executes from and issues requests
// Notes:   Programming time is a fixed count, no real flash array here
//          Busy clear and chip erase are taken only while idle
//          A refused store-program request sets interrupt status bit 1
//          Load protection follows the lock pair of the page read
//          Boot region is carved from the top of the NO_READ_WHILE_WRITE_REGION pages
//          Outputs are registered, so each answer lags its cause by at least one
//          clock; the CPU side must not count on same-cycle reactions
//
// How it works
// RULE_01: Ignore store-program requests from application code
// RULE_02: Boot code may program any page
// RULE_03: Fuses split regions; each region locked separately
// RULE_04: RWW programming keeps CPU running
// RULE_05: NO_READ_WHILE_WRITE_REGION programming halts CPU until done
// RULE_06: Boot region always inside NO_READ_WHILE_WRITE_REGION region
// RULE_07: Busy flag high while RWW blocked
// RULE_08: Software clears busy flag before RWW reads
// RULE_09: Software avoids RWW reads while programming
// RULE_10: Software disables or relocates interrupts meanwhile
// RULE_11: App lock pair and boot lock pair
// RULE_12: Lock pair encodings restrict writes/reads
// RULE_13: Lock bits set by software, cleared by erase
// RULE_14: Busy flag rises at programming start
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/10ps
module flash_rww_self_programming #(
  parameter int PAGE_W     = 16,
  parameter int NO_READ_WHILE_WRITE_REGION_PAGES = 32,
  parameter int NUM_PAGES  = 256
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // CPU side
  input  wire logic [PAGE_W-1:0] exec_page,
  input  wire logic [PAGE_W-1:0] load_page,
  input  wire logic              load_req,
  output logic                   load_denied,
  output logic                   cpu_halt,
  output logic                   rww_fetch_block,
  // Interrupt
  output logic                   irq
);
  import flash_ctl_pkg::*;

  // ****************************************
  // State
  // ****************************************
  // Registered state; every output below comes from one of these
  prog_state_t       state_reg, state_next;
  logic [15:0]       cnt_reg;
  logic [PAGE_W-1:0] page_reg;
  logic              rww_busy_reg;
  lock_bits_t        lock_reg;
  logic [1:0]        boot_size_fuses_reg;
  logic [1:0]        irq_st_reg;
  logic [1:0]        irq_en_reg;
  logic [31:0]       prdata_reg;
  logic              pready_reg;
  logic              pslverr_reg;
  logic              halt_reg;
  logic              deny_reg;
  logic              irq_reg;

  // ****************************************
  // Region decode
  // ****************************************
  // Three copies of one decoder fed by the same fuse value, so the
  // executing, target and load pages can never disagree on a boundary
  logic exec_boot;
  logic tgt_boot;
  logic tgt_no_read_while_write_region;
  logic load_boot;

  // Executing page: only boot code may start programming
  // RULE_03 fuse split
  flash_region_map #(.PAGE_W(PAGE_W), .NO_READ_WHILE_WRITE_REGION_PAGES(NO_READ_WHILE_WRITE_REGION_PAGES),
                     .NUM_PAGES(NUM_PAGES)) u_exec_map (
    .boot_size_fuses (boot_size_fuses_reg),
    .page            (exec_page),
    .in_boot         (exec_boot),
    .in_no_read_while_write_region         ()
  );

  // Target page: picks the lock pair and the halt
  // RULE_06 boot inside NO_READ_WHILE_WRITE_REGION
  flash_region_map #(.PAGE_W(PAGE_W), .NO_READ_WHILE_WRITE_REGION_PAGES(NO_READ_WHILE_WRITE_REGION_PAGES),
                     .NUM_PAGES(NUM_PAGES)) u_tgt_map (
    .boot_size_fuses (boot_size_fuses_reg),
    .page            (pwdata[31:16]),
    .in_boot         (tgt_boot),
    .in_no_read_while_write_region         (tgt_no_read_while_write_region)
  );

  // RULE_12 region of the page read
  flash_region_map #(.PAGE_W(PAGE_W), .NO_READ_WHILE_WRITE_REGION_PAGES(NO_READ_WHILE_WRITE_REGION_PAGES),
                     .NUM_PAGES(NUM_PAGES)) u_load_map (
    .boot_size_fuses (boot_size_fuses_reg),
    .page            (load_page),
    .in_boot         (load_boot),
    .in_no_read_while_write_region         ()
  );

  // ****************************************
  // Bus decode
  // ****************************************
  // One select per register, shared by writes, reads and the error
  wire sel_ctrl   = (paddr == CTRL_OFS);
  wire sel_status = (paddr == STATUS_OFS);
  wire sel_lock   = (paddr == LOCK_OFS);
  wire sel_fuse   = (paddr == FUSE_OFS);
  wire sel_irq_st = (paddr == IRQ_ST_OFS);
  wire sel_irq_en = (paddr == IRQ_EN_OFS);
  wire sel_irq_cl = (paddr == IRQ_CL_OFS);
  wire addr_ok    = sel_ctrl | sel_status | sel_lock | sel_fuse |
                    sel_irq_st | sel_irq_en | sel_irq_cl;

  // ****************************************
  // Write strobes
  // ****************************************
  // Access edge only: with pready in the term a stretched access
  // phase could never be taken twice
  wire bus_acc   = psel & penable & pready_reg;
  wire wr_acc    = bus_acc & pwrite;
  // One strobe per writable register
  wire wr_ctrl   = wr_acc & sel_ctrl;
  wire wr_lock   = wr_acc & sel_lock;
  wire wr_fuse   = wr_acc & sel_fuse;
  wire wr_irq_en = wr_acc & sel_irq_en;
  wire wr_irq_cl = wr_acc & sel_irq_cl;

  // ****************************************
  // Store-program request qualification
  // ****************************************
  // Start decode: go plus erase or write; lockset is not used
  wire idle      = (state_reg == ST_IDLE);
  wire go        = wr_ctrl & pwdata[CTRL_GO] &
                   (pwdata[CTRL_ERASE] | pwdata[CTRL_WRITE]);
  // Write protect looks at the pair of the region being written
  // RULE_11 pair per region
  wire [1:0] tgt_pair = tgt_boot ? lock_reg.boot_lock_pair
                                 : lock_reg.app_lock_pair;
  // RULE_12 write protect
  wire tgt_locked = lock_blocks_write(tgt_pair);
  // Refused: application code, a locked target, or a busy sequencer
  // RULE_01 boot code only
  // RULE_02 any target page
  wire go_ok     = go & idle & exec_boot & ~tgt_locked;
  wire go_bad    = go & ~go_ok;
  // An accepted start splits by the region of its target page
  wire start_rww = go_ok & ~tgt_no_read_while_write_region;
  wire start_nrw = go_ok & tgt_no_read_while_write_region;
  // Counter holds the cycles left; the last one ends the operation
  wire done      = ~idle & (cnt_reg == 16'h0001);

  // ****************************************
  // State machine
  // ****************************************
  // Next programming state; the default arm recovers from an
  // illegal state code by going back to idle
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_rww) begin
          state_next = ST_RWW;
        end else if (start_nrw) begin
          state_next = ST_NO_READ_WHILE_WRITE_REGION;
        end
      end
      ST_RWW, ST_NO_READ_WHILE_WRITE_REGION: begin
        if (done) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // Sequencer and programming counter; the page is kept for status
  // only, since no array is written here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 16'h0000;
      page_reg  <= '0;
    end else begin
      state_reg <= state_next;
      if (go_ok) begin
        cnt_reg  <= PROG_CYCLES;
        page_reg <= pwdata[31:16];
      end else if (!idle) begin
        cnt_reg <= cnt_reg - 16'h0001;
      end
    end
  end

  // ****************************************
  // Busy flag and CPU control
  // ****************************************
  // Flag stays up after completion until software clears it; a
  // clear while programming is dropped, so reads stay blocked
  wire rww_clr = wr_ctrl & pwdata[CTRL_RWWCLR] & idle;

  // RULE_07 flag held until cleared
  // A start beats a clear carried by the same control write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rww_busy_reg <= 1'b0;
    // RULE_14 set at start
    end else if (start_rww) begin
      rww_busy_reg <= 1'b1;
    // RULE_08 software clear
    end else if (rww_clr) begin
      rww_busy_reg <= 1'b0;
    end
  end

  // ****************************************
  // CPU halt and load protection
  // ****************************************
  // The halt covers the whole NO_READ_WHILE_WRITE_REGION operation, start cycle included;
  // an RWW operation never halts, so NO_READ_WHILE_WRITE_REGION code keeps running
  // RULE_05 halt whole NO_READ_WHILE_WRITE_REGION op
  // RULE_04 RWW keeps CPU running
  wire halt_next = start_nrw | ((state_reg == ST_NO_READ_WHILE_WRITE_REGION) & ~done);

  // Loads across regions are checked against the pair of the region
  // being read; a refusal shows one cycle after the request
  // RULE_12 cross-region load protect
  wire xload     = load_req & (exec_boot != load_boot);
  wire xpair_blk = load_boot ? lock_blocks_read(lock_reg.boot_lock_pair)
                             : lock_blocks_read(lock_reg.app_lock_pair);

  // Halt and denial registered so the core sees clean levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_reg <= 1'b0;
      deny_reg <= 1'b0;
    end else begin
      halt_reg <= halt_next;
      deny_reg <= xload & xpair_blk;
    end
  end

  // ****************************************
  // Lock bits and fuses
  // ****************************************
  // A lock write can only program bits (AND), so software can never
  // loosen protection; only the erase brings back all ones
  // Fuses are writable here as a stand-in for a programmer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_reg            <= lock_bits_t'(LOCK_RST);
      boot_size_fuses_reg <= BOOT_SIZE_FUSES_RST;
    end else begin
      // RULE_13 erase clears, writes only program
      if (wr_ctrl & pwdata[CTRL_CHIPERS] & idle) begin
        lock_reg <= lock_bits_t'(LOCK_RST);
      end else if (wr_lock & exec_boot) begin
        lock_reg <= lock_reg & lock_bits_t'(pwdata[3:0]);
      end
      if (wr_fuse) begin
        boot_size_fuses_reg <= pwdata[1:0];
      end
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  // Status bit 0 marks a finished operation, bit 1 a refused one
  wire [1:0] irq_set = {go_bad, done};

  // Set beats clear in the same cycle; irq looks at the set term too
  // so that it rises together with the status bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_reg <= 2'h0;
      irq_en_reg <= 2'h0;
      irq_reg    <= 1'b0;
    end else begin
      irq_st_reg <= (irq_st_reg & ~(wr_irq_cl ? pwdata[1:0] : 2'h0))
                    | irq_set;
      if (wr_irq_en) begin
        irq_en_reg <= pwdata[1:0];
      end
      irq_reg <= |((irq_st_reg | irq_set) & irq_en_reg);
    end
  end

  // ****************************************
  // APB read and answer
  // ****************************************
  // RULE_07 busy flag visible
  wire [31:0] status_w = {16'h0000, page_reg[7:0], 4'h0,
                          halt_reg, ~idle, rww_busy_reg, 1'b0};
  // Control, clear and unmapped offsets read as zero
  wire [31:0] rd_mux =
    sel_status ? status_w :
    sel_lock   ? {28'h0, lock_reg} :
    sel_fuse   ? {30'h0, boot_size_fuses_reg} :
    sel_irq_st ? {30'h0, irq_st_reg} :
    sel_irq_en ? {30'h0, irq_en_reg} : 32'h0;

  // No wait state: the setup edge latches the answer, so the
  // access phase always lasts one cycle; read data is zero elsewhere
  // and only the access cycle may carry an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0;
    end else begin
      pready_reg  <= psel & ~penable;
      pslverr_reg <= psel & ~penable & ~addr_ok;
      prdata_reg  <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Every output is a flop driven straight out
  assign prdata          = prdata_reg;
  assign pready          = pready_reg;
  assign pslverr         = pslverr_reg;
  assign cpu_halt        = halt_reg;
  assign load_denied     = deny_reg;
  assign rww_fetch_block = rww_busy_reg;
  assign irq             = irq_reg;
endmodule : flash_rww_self_programming

// ===== src/flash_ctl_pkg.sv
// Purpose: Shared constants and types for the flash self-programming control
// Assumes: 32-bit APB, one word per register
// Notes:   Lock pairs use 1 = unprogrammed, 0 = programmed
package flash_ctl_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] LOCK_OFS   = 8'h08;
  localparam logic [7:0] FUSE_OFS   = 8'h0c;
  localparam logic [7:0] IRQ_ST_OFS = 8'h10;
  localparam logic [7:0] IRQ_EN_OFS = 8'h14;
  localparam logic [7:0] IRQ_CL_OFS = 8'h18;

  // ****************************************
  // Reset values and field positions
  // ****************************************
  localparam logic [3:0] LOCK_RST     = 4'hf;
  localparam logic [1:0] BOOT_SIZE_FUSES_RST   = 2'h0;
  localparam int         CTRL_GO      = 0;
  localparam int         CTRL_ERASE   = 1;
  localparam int         CTRL_WRITE   = 2;
  localparam int         CTRL_LOCKSET = 3;
  localparam int         CTRL_RWWCLR  = 4;
  localparam int         CTRL_CHIPERS = 5;
  localparam int         IRQ_DONE     = 0;
  localparam int         IRQ_REJECT   = 1;

  // ****************************************
  // Timing
  // ****************************************
  localparam int         PROG_TIME_NS  = 4000;
  localparam int         CLK_PERIOD_NS = 10;
  localparam logic [15:0] PROG_CYCLES  =
    16'((PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RWW  = 2'b01,
    ST_NO_READ_WHILE_WRITE_REGION = 2'b10
  } prog_state_t;

  typedef struct packed {
    logic [1:0] app_lock_pair;
    logic [1:0] boot_lock_pair;
  } lock_bits_t;

  typedef struct packed {
    logic        valid;
    logic        erase;
    logic [15:0] page;
  } prog_req_t;

  // Lock pair blocks store-program writes when its low bit is programmed
  function automatic logic lock_blocks_write(input logic [1:0] pair);
    return ~pair[0];
  endfunction : lock_blocks_write

  // Lock pair blocks cross-region loads when its high bit is programmed
  function automatic logic lock_blocks_read(input logic [1:0] pair);
    return ~pair[1];
  endfunction : lock_blocks_read

endpackage : flash_ctl_pkg

// ===== src/flash_region_map.sv
// Purpose: Classify a flash page into boot / no-read-while-write regions
// Assumes: Boot region sits at the top of flash, sized by the fuses
// Notes:   Purely combinational
`timescale 1ns/10ps
module flash_region_map #(
  parameter int PAGE_W     = 16,
  parameter int NO_READ_WHILE_WRITE_REGION_PAGES = 32,
  parameter int NUM_PAGES  = 256
) (
  // Fuse setting
  input  wire logic [1:0]        boot_size_fuses,
  // Page to classify
  input  wire logic [PAGE_W-1:0] page,
  // Classification
  output logic                   in_boot,
  output logic                   in_no_read_while_write_region
);
  import flash_ctl_pkg::*;

  logic [PAGE_W-1:0] boot_pages;
  logic [PAGE_W-1:0] boot_start;
  logic [PAGE_W-1:0] no_read_while_write_region_start;

  // Boot size halves per fuse step, never above the NO_READ_WHILE_WRITE_REGION size
  assign boot_pages = PAGE_W'(NO_READ_WHILE_WRITE_REGION_PAGES) >> boot_size_fuses;
  assign boot_start = PAGE_W'(NUM_PAGES) - boot_pages;
  assign no_read_while_write_region_start = PAGE_W'(NUM_PAGES - NO_READ_WHILE_WRITE_REGION_PAGES);
  assign in_boot    = (page >= boot_start);
  assign in_no_read_while_write_region    = (page >= no_read_while_write_region_start);
endmodule : flash_region_map

// ===== verif/flash_rww_checker_assertions.sv
// Purpose: Port-level checks for the flash sequencer
// Assumes: APB answer one cycle after setup
// Notes:   Sees only the top-level ports
`timescale 1ns/10ps
module flash_rww_checker
  import flash_ctl_pkg::*;
#(
  parameter int PAGE_W     = 16,
  parameter int NO_READ_WHILE_WRITE_REGION_PAGES = 32,
  parameter int NUM_PAGES  = 256
) (
  // Clock, reset, bus
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // CPU side
  input wire logic [PAGE_W-1:0] exec_page,
  input wire logic              load_req,
  input wire logic              load_denied,
  input wire logic              cpu_halt,
  input wire logic              rww_fetch_block
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  localparam int NLO = NUM_PAGES - NO_READ_WHILE_WRITE_REGION_PAGES;
  logic [15:0] halt_cnt;
  // ****
  // Decode of control writes
  // ****
  wire ctl_wr = psel & penable & pready & pwrite & (paddr == CTRL_OFS);
  wire go_wr  = ctl_wr & pwdata[CTRL_GO]
              & (pwdata[CTRL_ERASE] | pwdata[CTRL_WRITE]);
  // Halt length, too long for a repetition
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) halt_cnt <= 16'h0;
    else halt_cnt <= cpu_halt ? halt_cnt + 16'h1 : 16'h0;
  end
  chk_ready_pulse: assert property (psel & !penable |=> pready ##1 !pready)
    else $error("bus answer not one cycle");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_app_ignored: assert property (
    go_wr && exec_page < NLO
    |=> (!$rose(rww_fetch_block) && !$rose(cpu_halt))[*2])
    else $error("program started from application code");
  chk_halt_length: assert property (
    $fell(cpu_halt) |-> halt_cnt == PROG_CYCLES)
    else $error("halt length wrong");
  chk_rww_runs: assert property (
    $rose(rww_fetch_block) |-> !cpu_halt ##1 !cpu_halt)
    else $error("core halted during block");
  chk_busy_start: assert property (
    $rose(rww_fetch_block) |-> $past(go_wr) || $past(go_wr, 2))
    else $error("busy rose without a start");
  chk_halt_start: assert property (
    $rose(cpu_halt) |-> $past(go_wr) || $past(go_wr, 2))
    else $error("halt rose without a start");
  chk_busy_holds: assert property (
    rww_fetch_block && !(ctl_wr && pwdata[CTRL_RWWCLR])
    |=> rww_fetch_block)
    else $error("busy dropped without clear");
  chk_deny_cause: assert property (
    load_denied |-> $past(load_req))
    else $error("denial without load");
  cover property ($fell(cpu_halt));
  cover property ($rose(rww_fetch_block));
  cover property (load_denied);
endmodule : flash_rww_checker

bind flash_rww_self_programming flash_rww_checker #(
  .PAGE_W(PAGE_W), .NO_READ_WHILE_WRITE_REGION_PAGES(NO_READ_WHILE_WRITE_REGION_PAGES), .NUM_PAGES(NUM_PAGES)
) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .exec_page(exec_page), .load_req(load_req),
  .load_denied(load_denied), .cpu_halt(cpu_halt),
  .rww_fetch_block(rww_fetch_block)
);

// ===== verif/cpu_boot_model.sv
// Purpose: Core running boot code, seen from the sequencer
// Assumes: Bench picks pages, model keeps fetch rules
// Notes:   Combinational, no interrupts taken
`timescale 1ns/10ps
module cpu_boot_model #(
  parameter int NLO = 224
) (
  // From bench
  input  wire logic [15:0] want_exec,
  input  wire logic [15:0] want_page,
  input  wire logic        want_load,
  // Device state
  input  wire logic        rww_fetch_block,
  input  wire logic        cpu_halt,
  // To device
  output logic [15:0]      exec_page,
  output logic [15:0]      load_page,
  output logic             load_req
);
  wire rww_hit = (want_page < NLO) & rww_fetch_block;
  assign exec_page = want_exec;
  assign load_req  = want_load & ~rww_hit & ~cpu_halt;
  // Released address shows inverse, never stale
  assign load_page = load_req ? want_page : ~want_page;
endmodule : cpu_boot_model

// ===== verif/flash_rww_self_programming_bench.sv
// Purpose: Self-checking bench for the flash sequencer
// Assumes: Default parameters, 400-cycle programming
// Notes:   Lock pairs swept per region, pages random
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module flash_rww_self_programming_bench;
  import flash_ctl_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, want_load;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, err, load_req, load_denied, cpu_halt, rwb, irq;
  logic [15:0] want_exec, want_page, exec_page, load_page, pg;
  logic [3:0] lk;
  int fails, cmp_count, cycles, seed;
  flash_rww_self_programming u_flash_rww_self_programming (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .exec_page(exec_page),
    .load_page(load_page), .load_req(load_req),
    .load_denied(load_denied), .cpu_halt(cpu_halt),
    .rww_fetch_block(rwb), .irq(irq));
  cpu_boot_model u_cpu_boot_model (
    .want_exec(want_exec), .want_page(want_page), .want_load(want_load),
    .rww_fetch_block(rwb), .cpu_halt(cpu_halt), .exec_page(exec_page),
    .load_page(load_page), .load_req(load_req));
  // ****
  // Bus tasks, wait until the answer comes
  // ****
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench's cycle ceiling bounds this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, m);
    apb(1'b0, a, 32'h0);
    `CHK(rd & m, e)
  endtask : rdchk
  task automatic test_done();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  // Clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles > 30000) begin
      fails++;
      test_done();
    end
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, want_load} = '0;
    presetn = 1'b0;
    cycles = 0;
    fails = 0;
    cmp_count = 0;
    seed = 80635;
    want_exec = 16'h7;
    want_page = 16'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(LOCK_OFS, 32'hf, 32'hf);
    rdchk(STATUS_OFS, 32'h0, 32'he);
    apb(1'b0, 8'h1c, 32'h0);
    `CHK(err, 1'b1)
    apb(1'b1, LOCK_OFS, 32'h0);
    rdchk(LOCK_OFS, 32'hf, 32'hf);
    lk = 4'($random(seed) & 3);
    apb(1'b1, FUSE_OFS, {28'h0, lk});
    rdchk(FUSE_OFS, {28'h0, lk}, 32'h3);
    $display("reset test done");
    apb(1'b1, CTRL_OFS, {16'h5, 16'h3});
    rdchk(STATUS_OFS, 32'h0, 32'he);
    apb(1'b1, IRQ_EN_OFS, 32'h1);
    rdchk(IRQ_ST_OFS, 32'h2, 32'h3);
    `CHK(irq, 1'b0)
    apb(1'b1, IRQ_EN_OFS, 32'h3);
    rdchk(IRQ_ST_OFS, 32'h2, 32'h3);
    `CHK(irq, 1'b1)
    apb(1'b1, IRQ_CL_OFS, 32'h2);
    apb(1'b1, IRQ_EN_OFS, 32'h1);
    `CHK(irq, 1'b0)
    $display("app test done");
    // Every lock pair code on both regions
    for (int r = 0; r < 2; r++) for (int p = 0; p < 4; p++) begin
      want_exec <= 16'hff;
      apb(1'b1, CTRL_OFS, 32'h21);
      lk = r ? {2'b11, 2'(p)} : {2'(p), 2'b11};
      apb(1'b1, LOCK_OFS, {28'h0, lk});
      rdchk(LOCK_OFS, {28'h0, lk}, 32'hf);
      pg = r ? 16'hff - 16'($random(seed) & 3) : 16'({$random(seed)} % 224);
      want_exec <= r ? 16'h7 : 16'hff;
      want_page <= pg;
      want_load <= 1'b1;
      repeat (2) @(posedge pclk);
      `CHK(load_denied, ~p[1])
      want_load <= 1'b0;
      want_exec <= 16'hff;
      apb(1'b1, IRQ_CL_OFS, 32'h3);
      apb(1'b1, CTRL_OFS, {pg, p[1] ? 16'h3 : 16'h5});
      if (!p[0]) rdchk(IRQ_ST_OFS, 32'h2, 32'h3);
      else begin
        rdchk(STATUS_OFS, {28'h0, 1'(r), 3'h4}, 32'hc);
        `CHK(cpu_halt, 1'(r))
        if (!r) `CHK(rwb, 1'b1)
        for (int n = 0; n < 600 && irq !== 1'b1; n++) @(posedge pclk);
        `CHK(irq, 1'b1)
        apb(1'b1, IRQ_CL_OFS, 32'h1);
        `CHK(rwb, ~1'(r))
        apb(1'b1, CTRL_OFS, 32'h10);
        apb(1'b1, IRQ_CL_OFS, 32'h0);
        `CHK(rwb, 1'b0)
        `CHK(irq, 1'b0)
      end
    end
    apb(1'b1, CTRL_OFS, 32'h21);
    rdchk(LOCK_OFS, 32'hf, 32'hf);
    $display("lock test done");
    test_done();
  end
endmodule : flash_rww_self_programming_bench
